//--- sim/gpio_port_register_bank_tb.sv
// Self-checking bench for the GPIO port register bank.
// Assumes zero wait APB answers and a plain board model on the pins.
`timescale 1ns/100ps

module gpio_port_register_bank_tb;
  import gpio_port_pkg::*;
  logic clock_in, rst_b_in, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, pin_irq_out;
  logic [7:0] pin_in, pin_out, pin_oe_out, ext_drive;
  logic [7:0] dir_m, out_m, rd, v, g, op; // Expected images and scratch
  logic er; // Last error response
  int miscompares, checks_done, cycles;

  gpio_port_register_bank #(.PINS(8)) gpio_port_register_bank_i (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .pin_irq_out(pin_irq_out));
  pin_model #(.PINS(8)) pin_model_i (.drv_in(pin_out), .oe_in(pin_oe_out),
    .ext_in(ext_drive), .level_out(pin_in));

  ////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Hang guard, well above the expected run
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare seen with expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1)
      @(posedge clock_in);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never re-drives psel in this step
    @(posedge clock_in);
  endtask

  // Register index to byte address
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {22'h0, idx, 2'h0}, d);
  endtask

  task automatic rdreg(input logic [7:0] idx);
    apb(1'b0, {22'h0, idx, 2'h0}, 8'h00);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Base write or set, clear, toggle alias on a model image
  function automatic logic [7:0] upd(logic [7:0] o, logic [7:0] m, logic [7:0] d);
    case (o)
      8'h00: return d;
      8'h01: return m | d;
      8'h02: return m & ~d;
      default: return m ^ d;
    endcase
  endfunction

  // Flag expected after a falling or a rising pin for a sense code
  function automatic logic [7:0] fall_hit(int c);
    return {7'h00, c == 1 || c == 3 || c == 5};
  endfunction

  // Low-level sense already set while low and cannot be cleared then
  function automatic logic [7:0] rise_hit(int c);
    return {7'h00, c == 1 || c == 2 || c == 5};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, rst_b_in} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ext_drive = 8'h00;
    {dir_m, out_m} = 16'h0000;
    void'($urandom(76750));
    settle(12);
    rst_b_in <= 1'b1;
    settle(1);
    // Registers start at zero; sense word 0x17 not read
    for (int i = 0; i < 17; i++)
    begin
      rdreg((i < 10) ? i[7:0] : 8'h10 + i[7:0] - 8'h0A);
      chk(rd, 8'h00);
    end
    chk(pin_oe_out, 8'h00);
    // Random alias traffic with input-register toggles mixed in
    for (int k = 0; k < 40; k++)
    begin
      g = 8'($urandom_range(1, 0) * 4);
      op = 8'($urandom_range(3, 0));
      v = 8'($urandom);
      ext_drive <= 8'($urandom);
      wr(g + op, v);
      if (g == 8'h00)
        dir_m = upd(op, dir_m, v);
      else
        out_m = upd(op, out_m, v);
      if (k % 5 == 0)
      begin
        wr(8'h08, v);
        out_m = out_m ^ v;
      end
      rdreg(g + 8'($urandom_range(3, 0)));
      chk(rd, (g != 8'h00) ? out_m : dir_m);
      chk(pin_oe_out, dir_m);
      chk(pin_out, out_m);
    end
    // Sampled levels, own outputs included where driven
    settle(4);
    rdreg(8'h08);
    chk(rd, (out_m & dir_m) | (ext_drive & ~dir_m));
    // Refused accesses: unmapped read, unmapped and unaligned writes
    rdreg(8'h0A);
    chk({7'h00, er}, 8'h01);
    chk(rd, 8'h00);
    wr(8'h0F, 8'hFF);
    chk({7'h00, er}, 8'h01);
    apb(1'b1, 32'h0000_0011, 8'hFF);
    chk({7'h00, er}, 8'h01);
    rdreg(8'h04);
    chk(rd, out_m);
    chk({7'h00, er}, 8'h00);
    // Every sense code on pin 0 as an input
    wr(8'h00, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      ext_drive[0] <= 1'b1;
      settle(6);
      wr(8'h10, c[7:0]);
      wr(8'h09, 8'hFF);
      ext_drive[0] <= 1'b0;
      settle(6);
      rdreg(8'h09);
      chk(rd, fall_hit(c));
      chk({7'h00, pin_irq_out}, fall_hit(c));
      rdreg(8'h08);
      chk({7'h00, rd[0]}, {7'h00, c == 4});
      wr(8'h09, 8'hFF);
      ext_drive[0] <= 1'b1;
      settle(6);
      wr(8'h09, 8'h00);
      rdreg(8'h09);
      chk(rd, rise_hit(c));
      wr(8'h09, 8'hFF);
      settle(2);
      rdreg(8'h09);
      chk(rd, 8'h00);
      chk({7'h00, pin_irq_out}, 8'h00);
    end
    // Mid-run reset with state and a pending flag
    wr(8'h01, 8'hA5);
    wr(8'h05, 8'h5A);
    wr(8'h10, 8'h05);
    ext_drive[0] <= 1'b0;
    settle(4);
    chk({7'h00, pin_irq_out}, 8'h01);
    rst_b_in <= 1'b0;
    settle(2);
    rst_b_in <= 1'b1;
    settle(1);
    chk(pin_oe_out, 8'h00);
    chk(pin_out, 8'h00);
    rdreg(8'h00);
    chk(rd, 8'h00);
    rdreg(8'h04);
    chk(rd, 8'h00);
    rdreg(8'h10);
    chk(rd, 8'h00);
    rdreg(8'h09);
    chk(rd, 8'h00);
    chk({7'h00, pin_irq_out}, 8'h00);
    end_of_test();
  end
endmodule

//--- sim/pin_model.sv
// Model of the board around the eight port pins.
// Assumes the bench sets the level that outside parts drive on each pin.
`timescale 1ns/100ps

module pin_model #(
  parameter int PINS = 8 // Pins in the port
)
(
  // From the port
  input wire logic [PINS-1:0] drv_in,
  input wire logic [PINS-1:0] oe_in,
  // From outside parts
  input wire logic [PINS-1:0] ext_in,
  // Resolved wire level
  output logic [PINS-1:0] level_out
);
  // Port wins where its driver is on, else outside part sets the wire
  assign level_out = (drv_in & oe_in) | (ext_in & ~oe_in);
endmodule

//--- verilog/gpio_port_pkg.sv
// Types shared by the GPIO port bank files.
// Assumes nothing beyond a SystemVerilog compiler.
package gpio_port_pkg;

  // One APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // Sense select code of one pin
  typedef logic [2:0] sense_t;

endpackage

//--- verilog/gpio_port_register_bank.sv
// Eight-bit GPIO port register bank with APB slave and pin drivers.
// Assumes an APB master on clock_in and asynchronous external pins.
// What this block does
// - Direction bit 1 enables pin driver
// - Direction never touches input buffer
// - Direction-set alias sets written one bits
// - Direction-clear alias clears written one bits
// - Direction-toggle alias inverts written one bits
// - Direction aliases read back direction register
// - Output level bit sets driven level
// - Level-set alias sets written one bits
// - Level-clear alias clears written one bits
// - Level-toggle alias inverts written one bits
// - Level aliases read back output level
// - Input register shows sampled pin levels
// - Input register write ones toggle outputs
// - Disabled buffer holds input value bit
// - Flag set on matching sense condition
// - Writing one clears interrupt flag
// - Sense field encodes edge, level, off
// - Pin request high while flag set
`timescale 1ns/100ps
`include "gpio_port_regs.svh"

module gpio_port_register_bank
  import gpio_port_pkg::*;
#(
  parameter int PINS = 8 // Pins in the port
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_out,
  // Pin interrupt request
  output logic pin_irq_out
);
  import gpio_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  apb_req_s req; // Bundled request
  logic wr_acc; // Write access phase
  logic rd_acc; // Read access phase
  logic [`ADDR_IDX_W-1:0] idx; // Register index
  logic [7:0] wbyte; // Low write byte
  logic mapped; // Address hits a register

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign idx = req.paddr[`ADDR_IDX_LSB +: `ADDR_IDX_W];
  assign wbyte = req.pwdata[7:0];
  assign wr_acc = req.psel && req.penable && req.pwrite;
  assign rd_acc = req.psel && req.penable && !req.pwrite;

  // Index hit, shared by every write strobe but the sense selects
  function automatic logic hit(input logic [`ADDR_IDX_W-1:0] a, input logic [3:0] target,
                               input logic [31:0] full);
    hit = (a == {1'b0, target}) && (full[1:0] == 2'b00)
          && (full[31:`ADDR_IDX_LSB+`ADDR_IDX_W] == '0);
  endfunction

  // Whether address falls in the sense block
  function automatic logic in_sense(input logic [31:0] full);
    in_sense = (full[1:0] == 2'b00) && (full[31:`ADDR_IDX_LSB+`ADDR_IDX_W] == '0)
               && full[`ADDR_IDX_LSB+4] && (full[`ADDR_IDX_LSB+3 +: 1] == 1'b0);
  endfunction

  // Zero wait states; unmapped address answers with slave error
  assign pready = 1'b1;
  assign mapped = in_sense(req.paddr) || ((req.paddr[1:0] == 2'b00)
                  && (req.paddr[31:`ADDR_IDX_LSB+`ADDR_IDX_W] == '0)
                  && (idx <= {1'b0, `IDX_PIN_EVENT_FLAG_REG}));
  assign pslverr = req.psel && req.penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic [PINS-1:0] sync1_r; // First stage, read only by second
  logic [PINS-1:0] sync2_r; // Stable pin level

  // Two-flop synchroniser on the asynchronous pins
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense select registers and per-pin detectors

  sense_t sense_r [PINS]; // Per-pin sense select
  sense_t sense_nxt [PINS];
  logic [PINS-1:0] level; // Sampled levels
  logic [PINS-1:0] hit_vec; // Sense matches this cycle

  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      // Sense select written at its own index
      always_comb
      begin
        sense_nxt[g] = sense_r[g];
        if (wr_acc && in_sense(req.paddr) && (idx[2:0] == 3'(g)))
          sense_nxt[g] = wbyte[2:0];
      end

      always_ff @(posedge clock_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          sense_r[g] <= `SENSE_RESET;
        else
          sense_r[g] <= sense_nxt[g];
      end

      pin_sense u_sense (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .sense_in(sense_r[g]),
        .pin_sync_in(sync2_r[g]),
        .level_out(level[g]),
        .hit_out(hit_vec[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Direction, output level and flag registers

  logic [7:0] dir_r; // Direction register
  logic [7:0] dir_nxt;
  logic [7:0] lvl_r; // Output level register
  logic [7:0] lvl_nxt;
  logic [7:0] flag_r; // Pin event flags
  logic [7:0] flag_nxt;
  logic [7:0] hit8; // Matches widened to a byte

  assign hit8 = 8'(hit_vec);

  // Next values from bus writes and pin events
  always_comb
  begin
    dir_nxt = dir_r;
    lvl_nxt = lvl_r;
    flag_nxt = flag_r;
    if (wr_acc)
    begin
      if (hit(idx, `IDX_DRIVE_ENABLE_REG, req.paddr))
        dir_nxt = wbyte;
      if (hit(idx, `IDX_DRIVE_ENABLE_SETTER, req.paddr))
        dir_nxt = dir_r | wbyte;
      if (hit(idx, `IDX_DRIVE_ENABLE_CLEARER, req.paddr))
        dir_nxt = dir_r & ~wbyte;
      if (hit(idx, `IDX_DRIVE_ENABLE_FLIPPER, req.paddr))
        dir_nxt = dir_r ^ wbyte;
      if (hit(idx, `IDX_PIN_LEVEL_LATCH, req.paddr))
        lvl_nxt = wbyte;
      if (hit(idx, `IDX_LEVEL_SETTER, req.paddr))
        lvl_nxt = lvl_r | wbyte;
      if (hit(idx, `IDX_LEVEL_CLEARER, req.paddr))
        lvl_nxt = lvl_r & ~wbyte;
      if (hit(idx, `IDX_LEVEL_FLIPPER, req.paddr))
        lvl_nxt = lvl_r ^ wbyte;
      // Input register write toggles outputs, samples untouched
      if (hit(idx, `IDX_SAMPLED_PIN_LEVELS, req.paddr))
        lvl_nxt = lvl_r ^ wbyte;
      if (hit(idx, `IDX_PIN_EVENT_FLAG_REG, req.paddr))
        flag_nxt = flag_r & ~wbyte;
    end
    // Set after clear so an event in the clearing cycle wins
    flag_nxt = flag_nxt | hit8;
  end

  // Registers
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dir_r <= `PORT_RESET;
      lvl_r <= `PORT_RESET;
      flag_r <= `PORT_RESET;
    end
    else
    begin
      dir_r <= dir_nxt;
      lvl_r <= lvl_nxt;
      flag_r <= flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and interrupt request

  // Driver enable from direction only; level presented regardless
  assign pin_oe_out = dir_r[PINS-1:0];
  assign pin_out = lvl_r[PINS-1:0];
  // Flags clear only by software, so request holds until then
  assign pin_irq_out = |flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] rbyte; // Selected register byte

  // Read mux; aliases return their base register
  always_comb
  begin
    rbyte = 8'h00;
    if (in_sense(req.paddr))
      rbyte = {5'h00, sense_r[idx[2:0]]};
    else
    begin
      case (idx[3:0])
        `IDX_DRIVE_ENABLE_REG, `IDX_DRIVE_ENABLE_SETTER,
        `IDX_DRIVE_ENABLE_CLEARER, `IDX_DRIVE_ENABLE_FLIPPER: rbyte = dir_r;
        `IDX_PIN_LEVEL_LATCH, `IDX_LEVEL_SETTER,
        `IDX_LEVEL_CLEARER, `IDX_LEVEL_FLIPPER: rbyte = lvl_r;
        `IDX_SAMPLED_PIN_LEVELS: rbyte = 8'(level);
        `IDX_PIN_EVENT_FLAG_REG: rbyte = flag_r;
        default: rbyte = 8'h00;
      endcase
    end
  end

  assign prdata = (rd_acc && mapped) ? {24'h000000, rbyte} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic dir_set_wr; // Helper strobes for checks
  logic lvl_tgl_wr;
  logic in_wr;
  logic flag_wr;
  assign dir_set_wr = wr_acc && hit(idx, `IDX_DRIVE_ENABLE_SETTER, req.paddr);
  assign lvl_tgl_wr = wr_acc && hit(idx, `IDX_LEVEL_FLIPPER, req.paddr);
  assign in_wr = wr_acc && hit(idx, `IDX_SAMPLED_PIN_LEVELS, req.paddr);
  assign flag_wr = wr_acc && hit(idx, `IDX_PIN_EVENT_FLAG_REG, req.paddr);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  chk_dir_set_bits: assert property (
    dir_set_wr |=> dir_r == ($past(dir_r) | $past(wbyte)))
    else $error("direction set alias wrong");
  chk_lvl_toggle: assert property (
    lvl_tgl_wr |=> lvl_r == ($past(lvl_r) ^ $past(wbyte)))
    else $error("level toggle alias wrong");
  chk_in_write_tgl: assert property (
    in_wr |=> lvl_r == ($past(lvl_r) ^ $past(wbyte)))
    else $error("input write did not toggle level");
  chk_flag_clear: assert property (
    flag_wr && (hit8 == 8'h00) |=> flag_r == ($past(flag_r) & ~$past(wbyte)))
    else $error("flag clear wrong");
  chk_flag_set: assert property (
    hit8 != 8'h00 |=> (flag_r & $past(hit8)) == $past(hit8))
    else $error("event flag not set");
  chk_oe_dir: assert property (
    pin_oe_out == dir_r[PINS-1:0])
    else $error("driver enable differs from direction");
  chk_irq_hold: assert property (
    pin_irq_out && !flag_wr |=> pin_irq_out)
    else $error("request dropped without clear");
  chk_alias_read: assert property (
    rd_acc && hit(idx, `IDX_DRIVE_ENABLE_FLIPPER, req.paddr) |-> prdata[7:0] == dir_r)
    else $error("direction alias read wrong");
  chk_hold_off: assert property (
    (sense_r[0] == `SENSE_BUFFER_OFF) ##1 (sense_r[0] == `SENSE_BUFFER_OFF)
      |-> $stable(level[0]))
    else $error("disabled input changed");
  // Clear alias drops only the written one bits
  chk_dir_clear_bits: assert property (
    wr_acc && hit(idx, `IDX_DRIVE_ENABLE_CLEARER, req.paddr)
      |=> dir_r == ($past(dir_r) & ~$past(wbyte)))
    else $error("direction clear alias wrong");
  // Toggle alias inverts only the written one bits
  chk_dir_toggle: assert property (
    wr_acc && hit(idx, `IDX_DRIVE_ENABLE_FLIPPER, req.paddr)
      |=> dir_r == ($past(dir_r) ^ $past(wbyte)))
    else $error("direction toggle alias wrong");
  // Level set alias raises only the written one bits
  chk_lvl_set_bits: assert property (
    wr_acc && hit(idx, `IDX_LEVEL_SETTER, req.paddr)
      |=> lvl_r == ($past(lvl_r) | $past(wbyte)))
    else $error("level set alias wrong");
  // Level clear alias drops only the written one bits
  chk_lvl_clear_bits: assert property (
    wr_acc && hit(idx, `IDX_LEVEL_CLEARER, req.paddr)
      |=> lvl_r == ($past(lvl_r) & ~$past(wbyte)))
    else $error("level clear alias wrong");
  // Level clear alias reads back the level register
  chk_lvl_alias_read: assert property (
    rd_acc && hit(idx, `IDX_LEVEL_CLEARER, req.paddr) |-> prdata[7:0] == lvl_r)
    else $error("level alias read wrong");
  // Buffer on: sample follows the synchronised pin whatever the direction
  chk_sample_follow: assert property (
    (sense_r[0] != `SENSE_BUFFER_OFF) |=> level[0] == $past(sync2_r[0]))
    else $error("input sample did not follow pin");
  // Low level sense flags every low cycle
  chk_low_level_flag: assert property (
    (sense_r[0] == `SENSE_LOW_LEVEL) && !sync2_r[0] |=> flag_r[0])
    else $error("low level not flagged");
  // Interrupt-off code never matches
  chk_no_event: assert property (
    (sense_r[0] == `SENSE_OFF_BUFFER_ON) |-> !hit_vec[0])
    else $error("event seen with sense off");
  // Rising edge against held sample sets the flag
  chk_rise_event: assert property (
    (sense_r[0] == `SENSE_RISING) && sync2_r[0] && !level[0] |=> flag_r[0])
    else $error("rising edge not flagged");
  // Falling edge against held sample sets the flag
  chk_fall_event: assert property (
    (sense_r[0] == `SENSE_FALLING) && !sync2_r[0] && level[0] |=> flag_r[0])
    else $error("falling edge not flagged");
  // A flag only goes away through a written one
  chk_flag_hold: assert property (
    flag_r[0] && !(flag_wr && wbyte[0]) |=> flag_r[0])
    else $error("flag lost without clear");
  // Writing zeros leaves every pending flag
  chk_zero_write: assert property (
    flag_wr && (wbyte == 8'h00) |=> (flag_r & $past(flag_r)) == $past(flag_r))
    else $error("zero write cleared a flag");

  cov_dir_set: cover property (dir_set_wr);
  cov_flag_set: cover property (hit8 != 8'h00);
  cov_flag_clr: cover property (flag_wr && flag_r != 8'h00);
  cov_set_vs_clr: cover property (flag_wr && hit8 != 8'h00);
  cov_low_level: cover property ((sense_r[0] == `SENSE_LOW_LEVEL) && flag_r[0]);

endmodule

//--- verilog/gpio_port_regs.svh
// Register offsets, field codes and reset values of the GPIO port bank.
// Assumes byte addressing on APB with one aligned 32-bit word per register.
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// Printed offsets are register indices; byte address is four times index
`define IDX_DRIVE_ENABLE_REG 4'h0
`define IDX_DRIVE_ENABLE_SETTER 4'h1
`define IDX_DRIVE_ENABLE_CLEARER 4'h2
`define IDX_DRIVE_ENABLE_FLIPPER 4'h3
`define IDX_PIN_LEVEL_LATCH 4'h4
`define IDX_LEVEL_SETTER 4'h5
`define IDX_LEVEL_CLEARER 4'h6
`define IDX_LEVEL_FLIPPER 4'h7
`define IDX_SAMPLED_PIN_LEVELS 4'h8
`define IDX_PIN_EVENT_FLAG_REG 4'h9
// Sense select block: one word per pin, index 0x10 + n
`define IDX_SENSE_BASE 5'h10
// Index field position in the byte address
`define ADDR_IDX_LSB 2
`define ADDR_IDX_W 5
// Reset value of every port register
`define PORT_RESET 8'h00
`define SENSE_RESET 3'h0
// Sense select codes
`define SENSE_OFF_BUFFER_ON 3'h0
`define SENSE_ANY_EDGE 3'h1
`define SENSE_RISING 3'h2
`define SENSE_FALLING 3'h3
`define SENSE_BUFFER_OFF 3'h4
`define SENSE_LOW_LEVEL 3'h5

`endif

//--- verilog/pin_sense.sv
// One pin's sampling and event detection.
// Assumes the pin level is already synchronised to clock_in.
`timescale 1ns/100ps
`include "gpio_port_regs.svh"

module pin_sense
  import gpio_port_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Configuration and pin
  input wire gpio_port_pkg::sense_t sense_in,
  input wire logic pin_sync_in,
  // Results
  output logic level_out,
  output logic hit_out
);
  import gpio_port_pkg::*;

  logic level_r; // Held sample
  logic level_nxt;
  logic buf_on; // Digital input buffer enabled

  // Buffer on for every code but the buffer-off code
  assign buf_on = (sense_in != `SENSE_BUFFER_OFF);

  // Sample only while buffer enabled, else hold
  always_comb
  begin
    level_nxt = buf_on ? pin_sync_in : level_r;
  end

  // Edge match against previous sample, low level against the pin
  always_comb
  begin
    case (sense_in)
      `SENSE_ANY_EDGE: hit_out = buf_on && (pin_sync_in != level_r);
      `SENSE_RISING: hit_out = pin_sync_in && !level_r;
      `SENSE_FALLING: hit_out = !pin_sync_in && level_r;
      `SENSE_LOW_LEVEL: hit_out = !pin_sync_in;
      default: hit_out = 1'b0; // Disabled and reserved codes
    endcase
  end

  // Sample register
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      level_r <= 1'b0;
    else
      level_r <= level_nxt;
  end

  assign level_out = level_r;

endmodule
